// *** design/fsp_flash_self_program_control.v ***
// self-programming sequencer for on-chip program flash
// assumes cpu strobes synchronous to mclk and a flash macro that
// raises flash_busy after flash_start and lowers it when done
`include "fsp_consts.vh"

module fsp_flash_self_program_control #(
  parameter WORD_BITS = 6,
  parameter PAGE_BITS = 8,
  parameter [7:0] STALL_FIRST_PAGE = 8'he0
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // cpu store and load instructions
  input wire spm_strobe,
  input wire lpm_strobe,
  input wire [15:0] cpu_z,
  input wire [15:0] cpu_r1r0,
  output reg lpm_override,
  output reg [7:0] lpm_data,
  output reg cpu_halt,
  output reg concurrent_region_busy,
  output wire spm_irq,
  // eeprom and non-volatile bytes
  input wire eeprom_write_busy,
  input wire [5:0] lock_bits,
  input wire [7:0] fuse_low_byte,
  input wire [7:0] fuse_high_byte,
  input wire [7:0] extended_fuse_byte,
  // flash macro
  output reg flash_start,
  output reg [1:0] flash_op,
  output reg [PAGE_BITS-1:0] flash_page,
  output reg [5:0] flash_lock_data,
  input wire flash_busy,
  input wire [WORD_BITS-1:0] flash_buf_idx,
  output wire [15:0] flash_buf_word
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_START = 2'd2;
  localparam ST_RUN = 2'd3;
  localparam NW = 1 << WORD_BITS;

  // true for an accepted low five command bits pattern
  function cmd_ok;
    input [4:0] c;
    begin
      cmd_ok = (c == `FSP_CMD_LOAD) || (c == `FSP_CMD_ERASE) ||
        (c == `FSP_CMD_WRITE) || (c == `FSP_CMD_LOCK) ||
        (c == `FSP_CMD_RRE);
    end
  endfunction

  reg [1:0] state_reg;
  reg [4:0] cmd_reg;
  reg [2:0] win_reg;
  reg irq_en_reg;
  reg [NW-1:0] valid_reg;
  reg valid_q_reg;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;

  wire [WORD_BITS-1:0] z_word = cpu_z[WORD_BITS:1];
  wire [PAGE_BITS-1:0] z_page = cpu_z[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  wire enable_bit = (state_reg != ST_IDLE);
  wire armed = (state_reg == ST_ARMED) && (win_reg != 3'h0);
  wire spm_go = armed && spm_strobe && !eeprom_write_busy;
  wire nv_cmd = (cmd_reg == `FSP_CMD_LOCK);
  wire lpm_win = armed && (win_reg > (`FSP_SPM_WIN - `FSP_LPM_WIN));
  wire nv_z = (cpu_z[15:2] == 14'h0000);
  wire addr_ok = hsel && htrans[1] && hready;
  wire ctrl_wr = wr_pend_reg && (wr_addr_reg == `FSP_CTRL_OFS);
  wire [4:0] wcmd = hwdata[4:0];
  wire busy_op = (state_reg == ST_START) || (state_reg == ST_RUN);
  wire cmd_take = ctrl_wr && !busy_op && !eeprom_write_busy &&
    cmd_ok(wcmd);
  wire buf_we = spm_go && (cmd_reg == `FSP_CMD_LOAD);
  wire op_done = (state_reg == ST_RUN) && !flash_busy;
  wire [7:0] ctrl_view;

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign ctrl_view = {irq_en_reg, concurrent_region_busy, 1'b0,
    cmd_reg[4:1], enable_bit};

  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr;
      end
      if (addr_ok && !hwrite) begin
        case (haddr)
          `FSP_CTRL_OFS: begin
            hrdata <= {24'h00_0000, ctrl_view};
          end
          `FSP_NVR_OFS: begin
            hrdata <= {7'h00, eeprom_write_busy, 2'h3, lock_bits,
              16'h0000};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command sequencer

  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_reg <= hwdata[`FSP_B_IRQEN];
    end
  end

  assign spm_irq = irq_en_reg && !enable_bit;

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 5'h00;
      win_reg <= 3'h0;
      flash_start <= 1'b0;
      flash_op <= 2'h0;
      flash_page <= {PAGE_BITS{1'b0}};
      flash_lock_data <= 6'h3f;
      cpu_halt <= 1'b0;
    end else begin
      flash_start <= 1'b0;
      if (win_reg != 3'h0) begin
        win_reg <= win_reg - 3'h1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (cmd_take) begin
            state_reg <= ST_ARMED;
            cmd_reg <= wcmd;
            win_reg <= `FSP_SPM_WIN;
          end
        end
        ST_ARMED: begin
          if (spm_go) begin
            case (cmd_reg)
              `FSP_CMD_WRITE: begin
                state_reg <= ST_START;
                flash_start <= 1'b1;
                flash_op <= `FSP_OP_WRITE;
                flash_page <= z_page;
                cpu_halt <= (z_page >= STALL_FIRST_PAGE);
              end
              `FSP_CMD_ERASE: begin
                state_reg <= ST_START;
                flash_start <= 1'b1;
                flash_op <= `FSP_OP_ERASE;
                flash_page <= z_page;
                cpu_halt <= (z_page >= STALL_FIRST_PAGE);
              end
              `FSP_CMD_LOCK: begin
                state_reg <= ST_START;
                flash_start <= 1'b1;
                flash_op <= `FSP_OP_LOCK;
                flash_lock_data <= cpu_r1r0[5:0];
                cpu_halt <= 1'b0;
              end
              default: begin
                state_reg <= ST_IDLE;
                cmd_reg <= 5'h00;
              end
            endcase
          end else if (lpm_strobe && lpm_win && nv_cmd &&
                       !eeprom_write_busy) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 5'h00;
          end else if (win_reg == 3'h0) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 5'h00;
          end
        end
        ST_START: begin
          if (flash_busy) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (op_done) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 5'h00;
            cpu_halt <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // concurrent region busy flag

  always @(posedge mclk) begin
    if (sys_rst) begin
      concurrent_region_busy <= 1'b0;
    end else if (spm_go && (z_page < STALL_FIRST_PAGE) &&
                 ((cmd_reg == `FSP_CMD_WRITE) ||
                  (cmd_reg == `FSP_CMD_ERASE))) begin
      concurrent_region_busy <= 1'b1;
    end else if (spm_go && !flash_busy &&
                 ((cmd_reg == `FSP_CMD_RRE) ||
                  (cmd_reg == `FSP_CMD_LOAD))) begin
      concurrent_region_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // load instruction answer

  always @(posedge mclk) begin
    if (sys_rst) begin
      lpm_override <= 1'b0;
      lpm_data <= 8'hff;
    end else begin
      lpm_override <= 1'b0;
      if (lpm_strobe && lpm_win && nv_cmd && nv_z &&
          !eeprom_write_busy) begin
        lpm_override <= 1'b1;
        case (cpu_z)
          `FSP_Z_FUSE_LO: begin
            lpm_data <= fuse_low_byte;
          end
          `FSP_Z_LOCK: begin
            lpm_data <= {2'h3, lock_bits};
          end
          `FSP_Z_FUSE_EXT: begin
            lpm_data <= extended_fuse_byte;
          end
          default: begin
            lpm_data <= fuse_high_byte;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // temporary page buffer

  wire [15:0] mem_rdata;

  fsp_page_mem #(
    .AW(WORD_BITS),
    .DW(16)
  ) u_mem (
    .clk(mclk),
    .we(buf_we),
    .waddr(z_word),
    .wdata(cpu_r1r0),
    .raddr(flash_buf_idx),
    .rdata(mem_rdata)
  );

  always @(posedge mclk) begin
    if (sys_rst && !flash_busy && !busy_op) begin
      valid_reg <= {NW{1'b0}};
    end else if (sys_rst) begin
      valid_reg <= valid_reg;
    end else if (op_done && (flash_op == `FSP_OP_WRITE)) begin
      valid_reg <= {NW{1'b0}};
    end else if (cmd_take && (wcmd == `FSP_CMD_RRE)) begin
      valid_reg <= {NW{1'b0}};
    end else if (eeprom_write_busy && !busy_op) begin
      valid_reg <= {NW{1'b0}};
    end else if (buf_we) begin
      valid_reg[z_word] <= 1'b1;
    end
    valid_q_reg <= valid_reg[flash_buf_idx];
  end

  assign flash_buf_word = valid_q_reg ? mem_rdata : `FSP_ERASED_WORD;

endmodule

// *** design/fsp_consts.vh ***
// constants for the flash self-programming sequencer
// assumes a 32-bit ahb-lite slave port and 16-bit program words
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// register byte offsets
`define FSP_CTRL_OFS 32'h0000_0000
`define FSP_NVR_OFS 32'h0000_0004

// control register bit positions
`define FSP_B_EN 0
`define FSP_B_ERASE 1
`define FSP_B_WRITE 2
`define FSP_B_LOCK 3
`define FSP_B_RRE 4
`define FSP_B_BUSY 6
`define FSP_B_IRQEN 7

// accepted low five command bits
`define FSP_CMD_LOAD 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_RRE 5'h11

// store window and load window, in cpu clocks
`define FSP_SPM_WIN 3'h4
`define FSP_LPM_WIN 3'h3

// z-pointer values that select the non-volatile bytes
`define FSP_Z_FUSE_LO 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_FUSE_EXT 16'h0002
`define FSP_Z_FUSE_HI 16'h0003

// flash operation codes
`define FSP_OP_ERASE 2'h1
`define FSP_OP_WRITE 2'h2
`define FSP_OP_LOCK 2'h3

// value of a word never loaded into the page buffer
`define FSP_ERASED_WORD 16'hffff

`endif

// *** design/fsp_page_mem.v ***
// temporary page buffer storage, one write and one read port
// assumes one clock; read data comes out of a register
module fsp_page_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  // clock
  input wire clk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // read port
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** bench/fsp_flash_model.sv ***
// flash macro model: answers each start pulse with a busy level
// assumes a one-cycle flash_start from the sequencer on mclk
module fsp_flash_model #(
  parameter BUSY_CYC = 12
) (
  input wire logic mclk,
  input wire logic flash_start,
  output logic flash_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  always @(posedge mclk) begin
    if (flash_start)
      cnt <= BUSY_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign flash_busy = (cnt != 0);
endmodule

// *** bench/fsp_checker_sva.sv ***
// port assertions for the flash self-programming sequencer
// assumes it is bound into the sequencer by the bind below
`include "fsp_consts.vh"
module fsp_checker_sva #(
  parameter PAGE_BITS = 8,
  parameter [7:0] STALL_FIRST_PAGE = 8'he0
) (
  input wire mclk,
  input wire sys_rst,
  input wire lpm_strobe,
  input wire [15:0] cpu_z,
  input wire [15:0] cpu_r1r0,
  input wire lpm_override,
  input wire [7:0] lpm_data,
  input wire cpu_halt,
  input wire concurrent_region_busy,
  input wire spm_irq,
  input wire eeprom_write_busy,
  input wire [5:0] lock_bits,
  input wire flash_start,
  input wire [1:0] flash_op,
  input wire [PAGE_BITS-1:0] flash_page,
  input wire [5:0] flash_lock_data
);
  logic [15:0] z_q;
  logic [15:0] r_q;
  wire wr_go = flash_start && flash_op == `FSP_OP_WRITE;
  wire lk_go = flash_start && flash_op == `FSP_OP_LOCK;
  always @(posedge mclk) begin
    z_q <= cpu_z;
    r_q <= cpu_r1r0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////
  a_start_pulse: assert property (flash_start |=> !flash_start)
    else $error("start held too long");
  a_stall_halt: assert property (
    wr_go && flash_page >= STALL_FIRST_PAGE |-> cpu_halt)
    else $error("stall write without halt");
  a_region_free: assert property (
    wr_go && flash_page < STALL_FIRST_PAGE |-> !cpu_halt)
    else $error("concurrent write halted cpu");
  a_region_block: assert property (
    wr_go && flash_page < STALL_FIRST_PAGE |-> concurrent_region_busy)
    else $error("region not blocked");
  a_page_latch: assert property (
    wr_go |-> flash_page == z_q[14:7])
    else $error("wrong page");
  a_lock_data: assert property (
    lk_go |-> flash_lock_data == r_q[5:0])
    else $error("wrong lock data");
  a_lock_free: assert property (lk_go |-> !cpu_halt)
    else $error("lock halted cpu");
  a_eeprom_block: assert property (
    $past(eeprom_write_busy) |-> !flash_start)
    else $error("start during eeprom write");
  a_load_cause: assert property (
    lpm_override |-> $past(lpm_strobe) && z_q <= 16'h3)
    else $error("stray override");
  a_lock_read: assert property (
    lpm_override && z_q == `FSP_Z_LOCK |->
    lpm_data[5:0] == $past(lock_bits))
    else $error("wrong lock byte");
  a_irq_quiet: assert property (cpu_halt |-> !spm_irq)
    else $error("irq during operation");
endmodule
bind fsp_flash_self_program_control fsp_checker_sva #(
  .PAGE_BITS(PAGE_BITS), .STALL_FIRST_PAGE(STALL_FIRST_PAGE)) chk_u (.*);

// *** bench/flash_self_program_control_tb_top.sv ***
// bench for the flash self-programming sequencer
// assumes the flash model answers each start with a busy level
`include "fsp_consts.vh"
module flash_self_program_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic spm_strobe = 0, lpm_strobe = 0, eeprom_write_busy = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, rn;
  logic [15:0] cpu_z = 0, cpu_r1r0 = 0, buf_m [64];
  logic [5:0] lock_bits = 0, flash_buf_idx = 0;
  logic [7:0] fuse_low_byte = 0, fuse_high_byte = 0;
  logic [7:0] extended_fuse_byte = 0, nv, p;
  wire hreadyout, hresp, lpm_override, cpu_halt, spm_irq;
  wire concurrent_region_busy, flash_start, flash_busy;
  wire [31:0] hrdata;
  wire [7:0] lpm_data, flash_page;
  wire [1:0] flash_op;
  wire [5:0] flash_lock_data;
  wire [15:0] flash_buf_word;
  int error_cnt = 0, checked = 0;
  fsp_flash_self_program_control dut_u (.hsize(3'h2),
    .hready(hreadyout), .*);
  fsp_flash_model flash_u (.*);
  always #2.5 mclk = ~mclk;
  //////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (!hreadyout);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cpu(logic s, logic [15:0] z, logic [15:0] r);
    spm_strobe <= s;
    lpm_strobe <= !s;
    cpu_z <= z;
    cpu_r1r0 <= r;
    cyc(1);
    spm_strobe <= 0;
    lpm_strobe <= 0;
  endtask
  task automatic load(logic [5:0] w, logic [15:0] d);
    ahb(1, 0, 32'h81);
    cpu(1, {9'h0, w, 1'b0}, d);
    buf_m[w] = d;
  endtask
  task automatic clr;
    foreach (buf_m[i]) buf_m[i] = 16'hffff;
  endtask
  task automatic chk_buf;
    for (int i = 0; i < 64; i++) begin
      flash_buf_idx <= i[5:0];
      cyc(2);
      chk("buf_word", buf_m[i], flash_buf_word);
    end
  endtask
  //////////////////////////////////////////
  initial begin
    rn = $urandom(32'h372d);
    {lock_bits, fuse_low_byte, fuse_high_byte} = rn[21:0];
    extended_fuse_byte = rn[29:22];
    clr();
    repeat (6) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    ahb(0, 32'h8, 0);
    chk("unmapped", 0, rd);
    ahb(0, `FSP_NVR_OFS, 0);
    chk("nv_reg", {8'h0, 2'b11, lock_bits, 16'h0}, rd);
    ahb(1, 0, 32'h80);
    cyc(0);
    chk("irq", 1, spm_irq);
    $display("registers done");
    for (int k = 0; k < 4; k++) begin
      rn = $urandom();
      load(6'(k * 21), rn[15:0]);
    end
    ahb(1, 0, 32'h87);
    cpu(1, 16'ha, 16'h1234);
    ahb(1, 0, 32'h81);
    cyc(5);
    cpu(1, 16'hc, 16'h5678);
    ahb(1, 0, 32'h81);
    cyc(3);
    cpu(1, 16'he, 16'h2468);
    buf_m[7] = 16'h2468;
    ahb(0, 0, 0);
    chk("ctrl", 32'h80, rd);
    chk_buf();
    $display("page load done");
    eeprom_write_busy <= 1;
    ahb(1, 0, 32'h85);
    cpu(1, 16'h7800, 0);
    ahb(0, 0, 0);
    chk("ctrl", 32'h80, rd);
    eeprom_write_busy <= 0;
    clr();
    chk_buf();
    $display("eeprom done");
    for (int j = 0; j < 2; j++) begin
      p = j ? 8'h10 : 8'hf0;
      rn = $urandom();
      load(6'd3, rn[15:0]);
      ahb(1, 0, 32'h85);
      cpu(1, {1'b0, p, 7'h0}, rn[31:16]);
      cyc(1);
      ahb(0, 0, 0);
      chk("ctrl", {24'h0, 1'b1, p < 8'he0, 6'h05}, rd);
      chk("halt", p >= 8'he0, cpu_halt);
      chk("irq", 0, spm_irq);
      do ahb(0, 0, 0); while (rd[0] !== 1'b0);
      clr();
      chk("halt", 0, cpu_halt);
      chk("region", p < 8'he0, concurrent_region_busy);
      load(6'd9, rn[31:16]);
      ahb(1, 0, 32'h91);
      cpu(1, 0, 0);
      clr();
      cyc(1);
      chk("region", 0, concurrent_region_busy);
      chk_buf();
    end
    $display("page write done");
    rn = $urandom();
    ahb(1, 0, 32'h89);
    cpu(1, 16'h1, {10'h3, rn[5:0]});
    chk("op", `FSP_OP_LOCK, flash_op);
    chk("lock_data", rn[5:0], flash_lock_data);
    chk("halt", 0, cpu_halt);
    do ahb(0, 0, 0); while (rd[0] !== 1'b0);
    $display("lock done");
    for (int z = 0; z < 5; z++) begin
      nv = z == 0 ? fuse_low_byte : z == 1 ? {2'b11, lock_bits} :
        z == 2 ? extended_fuse_byte : fuse_high_byte;
      ahb(1, 0, 32'h89);
      cpu(0, z[15:0], 0);
      chk("override", z < 4, lpm_override);
      if (z < 4) begin
        chk("nv", nv, lpm_data | {z == 1, z == 1, 6'h0});
        ahb(0, 0, 0);
        chk("ctrl", 32'h80, rd);
      end
    end
    cyc(6);
    cpu(0, 16'h1, 0);
    chk("override", 0, lpm_override);
    $display("nv read done");
    load(6'd1, 16'h55aa);
    sys_rst <= 1;
    cyc(1);
    sys_rst <= 0;
    clr();
    chk_buf();
    $display("reset done");
    end_sim();
  end
  initial begin
    #50000;
    error_cnt++;
    end_sim();
  end
endmodule
